// ### pkg/tbe_defs.svh
// Register map, field positions, reset values and sequence constants of the bit error tester
// Functional notes
// - Separate testers for local and backplane ports
// - Every transmitter and receiver enabled independently
// - Sequence length selectable, 2^15-1 or 2^23-1
// - Stream, start channel, count place sequence
// - Receiver locks on seeing the seed value
// - After lock, each bit mismatch increments counter
// - Error counter saturates at all ones
// - Control register enables transmit, receive per port
// - Transmit start holds stream and first channel
// - Transmit length counts extra following channels
// - Receive start holds stream and first channel
// - Receive length counts extra following channels
// - Count register shows accumulated errors
// - Allocated channels carry sequence, ignoring source, message
// - Receive channel numbering ignores input delay
// - Unallocated channels undefined while transmitting
// - Word bit 15 source, bit 14 message
// - Low output enable bit tristates channel
`ifndef TBE_DEFS_SVH
`define TBE_DEFS_SVH

// ==========================================================
// Register word indices (byte address is four times these)
`define TBE_ADDR_W 4
`define TBE_IDX_CTRL 4'h0
`define TBE_IDX_PORT_BIT 3
`define TBE_FLD_TX_START 3'h1
`define TBE_FLD_TX_LEN 3'h2
`define TBE_FLD_RX_START 3'h3
`define TBE_FLD_RX_LEN 3'h4
`define TBE_FLD_ERR_CNT 3'h5

// ==========================================================
// Control register: four bits per port, local at 0, backplane at 4
`define TBE_CTRL_PORT_STRIDE 4
`define TBE_CTRL_TX_EN 0
`define TBE_CTRL_RX_EN 1
`define TBE_CTRL_LONG 2
`define TBE_CTRL_LOCK 3
`define TBE_CTRL_RESET 8'h00

// ==========================================================
// Start and length register fields
`define TBE_CH_LSB 0
`define TBE_CH_W 9
`define TBE_STREAM_LSB 16
`define TBE_STREAM_W 5
`define TBE_ALLOC_RESET 23'h00_0000

// ==========================================================
// Connection word bits
`define TBE_CM_SRC 15
`define TBE_CM_MSG 14
`define TBE_CM_OE 13

// ==========================================================
// Sequence generator
`define TBE_LONG_W 23
`define TBE_SHORT_W 15
`define TBE_SHORT_TAP_A 14
`define TBE_SHORT_TAP_B 13
`define TBE_LONG_TAP_A 22
`define TBE_LONG_TAP_B 17
`define TBE_ERR_W 16
`define TBE_ERR_MAX 16'hFFFF

`endif

// ### pkg/tbe_pkg.sv
// Types shared by the bit error tester modules
package tbe_pkg;
	typedef struct packed
	{
		logic [4:0] stream;
		logic [8:0] channel;
		logic [2:0] bit_idx;
	} tbe_slot_t;

	typedef struct packed
	{
		logic [4:0] stream;
		logic [8:0] channel;
		logic [8:0] length;
	} tbe_alloc_t;

	typedef enum logic
	{
		TBE_SEARCH,
		TBE_LOCKED
	} tbe_rx_state_t;
endpackage

// ### rtl/tbe_prbs_lfsr.sv
// Maximal-length sequence generator, short or long polynomial
`include "tbe_defs.svh"
module tbe_prbs_lfsr
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_load,
	input wire logic i_step,
	input wire logic i_long,
	output logic o_bit
);
	import tbe_pkg::*;

	logic [`TBE_LONG_W-1:0] state_ff;
	logic [`TBE_LONG_W-1:0] nxt_state;
	wire short_fb = state_ff[`TBE_SHORT_TAP_A] ^ state_ff[`TBE_SHORT_TAP_B];
	wire long_fb = state_ff[`TBE_LONG_TAP_A] ^ state_ff[`TBE_LONG_TAP_B];

	// State always holds the last outputs, so an all-ones seed equals a run of ones on the line
	assign o_bit = i_long ? long_fb : short_fb;
	assign nxt_state = i_load ? {`TBE_LONG_W{1'b1}} :
		i_step ? {state_ff[`TBE_LONG_W-2:0], o_bit} : state_ff;

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			state_ff <= {`TBE_LONG_W{1'b1}};
		else
			state_ff <= nxt_state;
	end
endmodule

// ### rtl/tdm_prbs_bit_error_tester.sv
// Per-port sequence transmitters and checkers with an Avalon-MM register slave
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`include "tbe_defs.svh"
module tdm_prbs_bit_error_tester
(
	input wire logic I_CLK,
	input wire logic I_RESETN,
	// Avalon-MM slave, word addressed
	input wire logic [`TBE_ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// Local port output slot
	input wire logic I_LOC_TX_STB,
	input wire tbe_pkg::tbe_slot_t I_LOC_TX_SLOT,
	input wire logic [15:0] I_LOC_CM_WORD,
	input wire logic I_LOC_LOC_SRC_BIT,
	input wire logic I_LOC_BP_SRC_BIT,
	output logic O_LOC_TX_BIT,
	output logic O_LOC_TX_OE,
	// Local port input slot
	input wire logic I_LOC_RX_STB,
	input wire tbe_pkg::tbe_slot_t I_LOC_RX_SLOT,
	input wire logic I_LOC_RX_BIT,
	// Backplane port output slot
	input wire logic I_BP_TX_STB,
	input wire tbe_pkg::tbe_slot_t I_BP_TX_SLOT,
	input wire logic [15:0] I_BP_CM_WORD,
	input wire logic I_BP_LOC_SRC_BIT,
	input wire logic I_BP_BP_SRC_BIT,
	output logic O_BP_TX_BIT,
	output logic O_BP_TX_OE,
	// Backplane port input slot
	input wire logic I_BP_RX_STB,
	input wire tbe_pkg::tbe_slot_t I_BP_RX_SLOT,
	input wire logic I_BP_RX_BIT
);
	import tbe_pkg::*;

	localparam int NPORT = 2;

	// ==========================================================
	// Allocation decode, shared by all four windows
	// End is one bit wider than a channel, so a long run never wraps back to channel zero
	function automatic logic in_window(input tbe_alloc_t a, input tbe_slot_t s);
		logic [9:0] last;
		last = {1'b0, a.channel} + {1'b0, a.length};
		in_window = (s.stream == a.stream) && (s.channel >= a.channel) && ({1'b0, s.channel} <= last);
	endfunction

	// ==========================================================
	// Port signals gathered into arrays, index 0 local, 1 backplane
	logic [NPORT-1:0] tx_stb;
	logic [NPORT-1:0] rx_stb;
	logic [NPORT-1:0] rx_bit;
	logic [NPORT-1:0] own_src;
	logic [NPORT-1:0] other_src;
	tbe_slot_t tx_slot [NPORT];
	tbe_slot_t rx_slot [NPORT];
	logic [15:0] cm_word [NPORT];

	assign tx_stb = {I_BP_TX_STB, I_LOC_TX_STB};
	assign rx_stb = {I_BP_RX_STB, I_LOC_RX_STB};
	assign rx_bit = {I_BP_RX_BIT, I_LOC_RX_BIT};
	// High source bit selects the port's own side on both ports
	assign own_src = {I_BP_BP_SRC_BIT, I_LOC_LOC_SRC_BIT};
	assign other_src = {I_BP_LOC_SRC_BIT, I_LOC_BP_SRC_BIT};
	assign tx_slot[0] = I_LOC_TX_SLOT;
	assign tx_slot[1] = I_BP_TX_SLOT;
	assign rx_slot[0] = I_LOC_RX_SLOT;
	assign rx_slot[1] = I_BP_RX_SLOT;
	assign cm_word[0] = I_LOC_CM_WORD;
	assign cm_word[1] = I_BP_CM_WORD;

	// ==========================================================
	// Bus slave: one wait cycle, write commits when waitrequest is low
	logic waitrequest_ff;
	logic [31:0] readdata_ff;
	logic [31:0] rd_value;
	wire bus_req = I_AVS_READ | I_AVS_WRITE;
	wire wr_commit = I_AVS_WRITE & ~waitrequest_ff;
	wire rd_capture = I_AVS_READ & waitrequest_ff;
	wire addr_port = I_AVS_ADDRESS[`TBE_IDX_PORT_BIT];
	wire [2:0] addr_fld = I_AVS_ADDRESS[2:0];
	wire ctrl_sel = (I_AVS_ADDRESS == `TBE_IDX_CTRL);
	wire nxt_waitrequest = ~(bus_req & waitrequest_ff);

	// Read data is taken on the wait cycle, so it already stands when waitrequest drops
	always_ff @(posedge I_CLK or negedge I_RESETN)
	begin
		if (!I_RESETN)
		begin
			waitrequest_ff <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end
		else
		begin
			waitrequest_ff <= nxt_waitrequest;
			if (rd_capture)
				readdata_ff <= rd_value;
		end
	end

	assign O_AVS_WAITREQUEST = waitrequest_ff;
	assign O_AVS_READDATA = readdata_ff;

	// ==========================================================
	// Per-port control, allocation and engine state
	logic [NPORT-1:0] tx_en_ff;
	logic [NPORT-1:0] rx_en_ff;
	logic [NPORT-1:0] rx_en_d_ff;
	logic [NPORT-1:0] long_ff;
	logic [NPORT-1:0] locked;
	logic [7:0] ctrl_word;
	logic [31:0] port_rd [NPORT];
	logic [`TBE_ERR_W-1:0] err_cnt_ff [NPORT];
	tbe_alloc_t tx_alloc_ff [NPORT];
	tbe_alloc_t rx_alloc_ff [NPORT];

	// One copy per port; both share the bus decode above
	genvar p;
	generate
		for (p = 0; p < NPORT; p++)
		begin : g_port
			// ------------------------------------------------
			// Register writes for this port
			wire port_wr = wr_commit & (addr_port == 1'(p));
			wire ctrl_wr = wr_commit & ctrl_sel;
			localparam int CB = p * `TBE_CTRL_PORT_STRIDE;
			wire [4:0] wd_stream = I_AVS_WRITEDATA[`TBE_STREAM_LSB +: `TBE_STREAM_W];
			wire [8:0] wd_ch = I_AVS_WRITEDATA[`TBE_CH_LSB +: `TBE_CH_W];
			wire [3:0] wd_ctrl = I_AVS_WRITEDATA[CB +: `TBE_CTRL_PORT_STRIDE];
			// Unmapped words and the read-only count match no select, so their writes are dropped
			wire wr_tx_start = port_wr & (addr_fld == `TBE_FLD_TX_START);
			wire wr_tx_len = port_wr & (addr_fld == `TBE_FLD_TX_LEN);
			wire wr_rx_start = port_wr & (addr_fld == `TBE_FLD_RX_START);
			wire wr_rx_len = port_wr & (addr_fld == `TBE_FLD_RX_LEN);

			always_ff @(posedge I_CLK or negedge I_RESETN)
			begin
				if (!I_RESETN)
				begin
					tx_en_ff[p] <= 1'b0;
					rx_en_ff[p] <= 1'b0;
					long_ff[p] <= 1'b0;
					rx_en_d_ff[p] <= 1'b0;
					tx_alloc_ff[p] <= `TBE_ALLOC_RESET;
					rx_alloc_ff[p] <= `TBE_ALLOC_RESET;
				end
				else
				begin
					rx_en_d_ff[p] <= rx_en_ff[p];
					if (ctrl_wr)
					begin
						tx_en_ff[p] <= wd_ctrl[`TBE_CTRL_TX_EN];
						rx_en_ff[p] <= wd_ctrl[`TBE_CTRL_RX_EN];
						long_ff[p] <= wd_ctrl[`TBE_CTRL_LONG];
					end
					if (wr_tx_start)
					begin
						tx_alloc_ff[p].stream <= wd_stream;
						tx_alloc_ff[p].channel <= wd_ch;
					end
					if (wr_tx_len)
						tx_alloc_ff[p].length <= wd_ch;
					if (wr_rx_start)
					begin
						rx_alloc_ff[p].stream <= wd_stream;
						rx_alloc_ff[p].channel <= wd_ch;
					end
					if (wr_rx_len)
						rx_alloc_ff[p].length <= wd_ch;
				end
			end

			// ------------------------------------------------
			// Transmitter
			logic tx_bit_ff;
			logic tx_oe_ff;
			logic prbs_tx_bit;
			wire tx_hit = tx_en_ff[p] & in_window(tx_alloc_ff[p], tx_slot[p]);
			wire tx_step = tx_hit & tx_stb[p];
			// Message byte goes out most significant bit first
			wire [2:0] msg_idx = 3'h7 - tx_slot[p].bit_idx;
			wire msg_bit = cm_word[p][msg_idx];
			wire switched_bit = cm_word[p][`TBE_CM_SRC] ? own_src[p] : other_src[p];
			wire normal_bit = cm_word[p][`TBE_CM_MSG] ? msg_bit : switched_bit;
			// Filler on unallocated channels is a constant high; the side cannot switch meanwhile
			wire nxt_tx_bit = tx_hit ? prbs_tx_bit : (tx_en_ff[p] ? 1'b1 : normal_bit);
			// Enable bit still gates the pin, so allocated channels need it set high
			wire nxt_tx_oe = cm_word[p][`TBE_CM_OE];

			// Generator reseeds while sending is off, so every enable starts from the seed
			tbe_prbs_lfsr u_tx_gen
			(
				.i_clk(I_CLK),
				.i_resetn(I_RESETN),
				.i_load(~tx_en_ff[p]),
				.i_step(tx_step),
				.i_long(long_ff[p]),
				.o_bit(prbs_tx_bit)
			);

			always_ff @(posedge I_CLK or negedge I_RESETN)
			begin
				if (!I_RESETN)
				begin
					tx_bit_ff <= 1'b1;
					tx_oe_ff <= 1'b0;
				end
				else if (tx_stb[p])
				begin
					tx_bit_ff <= nxt_tx_bit;
					tx_oe_ff <= nxt_tx_oe;
				end
			end

			// ------------------------------------------------
			// Receiver: raw input channel count, no input delay compensation
			tbe_rx_state_t state_ff;
			tbe_rx_state_t nxt_state;
			logic [`TBE_LONG_W-1:0] hist_ff;
			logic [`TBE_ERR_W-1:0] nxt_err;
			logic exp_bit;
			wire rx_hit = rx_en_ff[p] & rx_stb[p] & in_window(rx_alloc_ff[p], rx_slot[p]);
			wire rx_restart = rx_en_ff[p] & ~rx_en_d_ff[p];
			wire rx_idle = ~rx_en_ff[p];
			wire [`TBE_LONG_W-1:0] nxt_hist = {hist_ff[`TBE_LONG_W-2:0], rx_bit[p]};
			wire seed_seen = long_ff[p] ? (&nxt_hist) : (&nxt_hist[`TBE_SHORT_W-1:0]);
			wire lock_evt = rx_hit & (state_ff == TBE_SEARCH) & seed_seen;
			wire check = rx_hit & (state_ff == TBE_LOCKED);
			wire mismatch = check & (rx_bit[p] != exp_bit);
			wire at_max = (err_cnt_ff[p] == `TBE_ERR_MAX);
			// Count sticks at all ones, so software sees a full count rather than a wrapped one
			wire err_step = mismatch & ~at_max;

			assign nxt_err = rx_restart ? '0 :
				err_step ? err_cnt_ff[p] + 16'h0001 : err_cnt_ff[p];
			// Switching checking off keeps the count for software but drops lock
			assign nxt_state = (rx_restart || rx_idle) ? TBE_SEARCH :
				lock_evt ? TBE_LOCKED : state_ff;
			assign locked[p] = (state_ff == TBE_LOCKED);

			// Reference reloads the seed at lock, matching a sender that starts from the seed
			tbe_prbs_lfsr u_rx_ref
			(
				.i_clk(I_CLK),
				.i_resetn(I_RESETN),
				.i_load(lock_evt),
				.i_step(check),
				.i_long(long_ff[p]),
				.o_bit(exp_bit)
			);

			always_ff @(posedge I_CLK or negedge I_RESETN)
			begin
				if (!I_RESETN)
				begin
					state_ff <= TBE_SEARCH;
					hist_ff <= '0;
					err_cnt_ff[p] <= '0;
				end
				else
				begin
					state_ff <= nxt_state;
					err_cnt_ff[p] <= nxt_err;
					// History is already empty on the enabling edge, so the bit of that edge starts the search
					if (rx_idle)
						hist_ff <= '0;
					else if (rx_hit)
						hist_ff <= nxt_hist;
				end
			end

			// ------------------------------------------------
			// Readback of this port's registers
			// Lock reads back the live state; a write to it is dropped
			assign ctrl_word[CB +: `TBE_CTRL_PORT_STRIDE] = {locked[p], long_ff[p], rx_en_ff[p], tx_en_ff[p]};
			assign port_rd[p] =
				(addr_fld == `TBE_FLD_TX_START) ? {11'h000, tx_alloc_ff[p].stream, 7'h00, tx_alloc_ff[p].channel} :
				(addr_fld == `TBE_FLD_TX_LEN) ? {23'h00_0000, tx_alloc_ff[p].length} :
				(addr_fld == `TBE_FLD_RX_START) ? {11'h000, rx_alloc_ff[p].stream, 7'h00, rx_alloc_ff[p].channel} :
				(addr_fld == `TBE_FLD_RX_LEN) ? {23'h00_0000, rx_alloc_ff[p].length} :
				(addr_fld == `TBE_FLD_ERR_CNT) ? {16'h0000, err_cnt_ff[p]} : 32'h0000_0000;

			if (p == 0)
			begin : g_loc_out
				assign O_LOC_TX_BIT = tx_bit_ff;
				assign O_LOC_TX_OE = tx_oe_ff;
			end
			else
			begin : g_bp_out
				assign O_BP_TX_BIT = tx_bit_ff;
				assign O_BP_TX_OE = tx_oe_ff;
			end
		end
	endgenerate

	// ==========================================================
	// Read selection; unmapped words read zero
	assign rd_value = ctrl_sel ? {24'h00_0000, ctrl_word} : port_rd[addr_port];
endmodule

// ### tb/tbe_asserts.sv
// Concurrent checks on the bit error tester ports
`include "tbe_defs.svh"
module tbe_asserts
(
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic [`TBE_ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	input wire logic I_LOC_TX_STB,
	input wire logic [15:0] I_LOC_CM_WORD,
	input wire logic O_LOC_TX_BIT,
	input wire logic O_LOC_TX_OE,
	input wire logic I_BP_TX_STB,
	input wire logic [15:0] I_BP_CM_WORD,
	input wire logic O_BP_TX_OE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESETN);
	// ==========================================================
	// Register bus
	a_wait_one: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("waitrequest not low one cycle after request");
	a_wait_pulse: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	a_wait_idle: assert property (!(I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest dropped without request");
	a_rd_hold: assert property (!(I_AVS_READ && O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA))
		else $error("read data changed without a read");
	a_rd_unmapped: assert property (I_AVS_READ && O_AVS_WAITREQUEST && I_AVS_ADDRESS inside {4'h6, 4'h7, 4'h8}
		|=> O_AVS_READDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	// ==========================================================
	// Output slots
	a_loc_oe: assert property (I_LOC_TX_STB |=> O_LOC_TX_OE == $past(I_LOC_CM_WORD[`TBE_CM_OE]))
		else $error("local enable does not follow connection word");
	a_bp_oe: assert property (I_BP_TX_STB |=> O_BP_TX_OE == $past(I_BP_CM_WORD[`TBE_CM_OE]))
		else $error("backplane enable does not follow connection word");
	a_loc_hold: assert property (!I_LOC_TX_STB |=> $stable(O_LOC_TX_BIT) && $stable(O_LOC_TX_OE))
		else $error("local output changed without strobe");
	a_reset_out: assert property ($rose(I_RESETN) |-> O_AVS_WAITREQUEST && O_LOC_TX_BIT && !O_LOC_TX_OE)
		else $error("outputs not at reset values after release");
endmodule
bind tdm_prbs_bit_error_tester tbe_asserts u_chk (.I_CLK, .I_RESETN, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE,
	.O_AVS_READDATA, .O_AVS_WAITREQUEST, .I_LOC_TX_STB, .I_LOC_CM_WORD, .O_LOC_TX_BIT, .O_LOC_TX_OE,
	.I_BP_TX_STB, .I_BP_CM_WORD, .O_BP_TX_OE);

// ### tb/tbe_far_model.sv
// Far-side serial equipment: strobes slots, checks sent sequence, sends a sequence back
module tbe_far_model
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_run,
	input wire logic i_long,
	input wire logic i_flip,
	input wire logic i_tx_bit,
	output logic o_stb,
	output tbe_pkg::tbe_slot_t o_slot,
	output logic o_rx_bit,
	output logic [15:0] o_bad,
	output logic [15:0] o_flips
);
	timeunit 1ns;
	timeprecision 1ps;
	import tbe_pkg::*;
	logic [4:0] pos_ff;
	logic [22:0] ref_ff;
	logic [22:0] gen_ff;
	logic in_tx_ff;
	logic run_ff;
	function automatic logic fb(input logic [22:0] s, input logic lng);
		fb = lng ? s[22] ^ s[17] : s[14] ^ s[13];
	endfunction
	// Raw channel numbers, no input delay applied
	assign o_slot = '{stream: 5'h00, channel: {7'h00, pos_ff[4:3]}, bit_idx: pos_ff[2:0]};
	// Oldest stage first: the seed run of ones goes out ahead of the sequence
	assign o_rx_bit = (i_run ? (i_long ? gen_ff[22] : gen_ff[14]) : 1'b0) ^ i_flip;
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			{pos_ff, in_tx_ff, run_ff, o_stb, o_bad, o_flips} <= '0;
			ref_ff <= '1;
			gen_ff <= '1;
		end
		else
		begin
			o_stb <= 1'b1;
			pos_ff <= pos_ff + (o_stb ? 5'h01 : 5'h00);
			in_tx_ff <= o_stb && (pos_ff[4] ^ pos_ff[3]); // Channels 1 and 2 carry the sequence
			run_ff <= i_run && o_stb;
			if (run_ff && in_tx_ff)
			begin
				ref_ff <= {ref_ff[21:0], fb(ref_ff, i_long)};
				if (i_tx_bit !== fb(ref_ff, i_long))
					o_bad <= o_bad + 16'h0001;
			end
			else if (run_ff && i_tx_bit !== 1'b1)
				o_bad <= o_bad + 16'h0001;
			if (i_run && o_stb)
			begin
				gen_ff <= {gen_ff[21:0], fb(gen_ff, i_long)};
				o_flips <= o_flips + (i_flip ? 16'h0001 : 16'h0000);
			end
			if (!i_run)
				ref_ff <= '1;
		end
	end
endmodule

// ### tb/tdm_prbs_bit_error_tester_tb_top.sv
// Self-checking bench for the bit error tester
module tdm_prbs_bit_error_tester_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tbe_pkg::*;
	typedef struct packed {logic [3:0] addr; logic [31:0] wdata; logic [31:0] rdata;} tbe_row_t;
	logic clk, rst_n, rd, wr, waitreq, run, flip_l, flip_b, stb_l, stb_b, rxb_l, rxb_b, txb_l, txb_b, oe_l, oe_b, src_l;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [15:0] cm_l, cm_b, bad_l, bad_b, flips_l, flips_b;
	tbe_slot_t slot_l, slot_b;
	int n_mismatch = 0;
	int n_tests = 0;
	tbe_row_t rows [16] = '{
		'{4'h0, 32'h0000_0088, 32'h0000_0000}, '{4'h1, 32'hFFFF_FFFF, 32'h001F_01FF},
		'{4'h2, 32'hFFFF_FFFF, 32'h0000_01FF}, '{4'h3, 32'hFFFF_FFFF, 32'h001F_01FF},
		'{4'h4, 32'hFFFF_FFFF, 32'h0000_01FF}, '{4'h5, 32'hFFFF_FFFF, 32'h0000_0000},
		'{4'h6, 32'hFFFF_FFFF, 32'h0000_0000}, '{4'hD, 32'h0000_1234, 32'h0000_0000},
		'{4'h1, 32'h0000_0001, 32'h0000_0001}, '{4'h2, 32'h0000_0001, 32'h0000_0001},
		'{4'h3, 32'h0000_0000, 32'h0000_0000}, '{4'h4, 32'h0000_0003, 32'h0000_0003},
		'{4'h9, 32'h0000_0001, 32'h0000_0001}, '{4'hA, 32'h0000_0001, 32'h0000_0001},
		'{4'hB, 32'h0000_0000, 32'h0000_0000}, '{4'hC, 32'h0000_0003, 32'h0000_0003}};
	tdm_prbs_bit_error_tester dut_u (.I_CLK(clk), .I_RESETN(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
		.I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
		.I_LOC_TX_STB(stb_l), .I_LOC_TX_SLOT(slot_l), .I_LOC_CM_WORD(cm_l), .I_LOC_LOC_SRC_BIT(src_l),
		.I_LOC_BP_SRC_BIT(1'b0), .O_LOC_TX_BIT(txb_l), .O_LOC_TX_OE(oe_l), .I_LOC_RX_STB(stb_l),
		.I_LOC_RX_SLOT(slot_l), .I_LOC_RX_BIT(rxb_l), .I_BP_TX_STB(stb_b), .I_BP_TX_SLOT(slot_b),
		.I_BP_CM_WORD(cm_b), .I_BP_LOC_SRC_BIT(1'b0), .I_BP_BP_SRC_BIT(1'b0), .O_BP_TX_BIT(txb_b),
		.O_BP_TX_OE(oe_b), .I_BP_RX_STB(stb_b), .I_BP_RX_SLOT(slot_b), .I_BP_RX_BIT(rxb_b));
	tbe_far_model u_far_l (.i_clk(clk), .i_resetn(rst_n), .i_run(run), .i_long(1'b0), .i_flip(flip_l),
		.i_tx_bit(txb_l), .o_stb(stb_l), .o_slot(slot_l), .o_rx_bit(rxb_l), .o_bad(bad_l), .o_flips(flips_l));
	tbe_far_model u_far_b (.i_clk(clk), .i_resetn(rst_n), .i_run(run), .i_long(1'b1), .i_flip(flip_b),
		.i_tx_bit(txb_b), .o_stb(stb_b), .o_slot(slot_b), .o_rx_bit(rxb_b), .o_bad(bad_b), .o_flips(flips_b));
	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do
			@(posedge clk);
		while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================================
	// Stimulus
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (72000) @(posedge clk);
		n_mismatch++;
		stop_test;
	end
	initial
	begin
		{rst_n, rd, wr, run, flip_l, flip_b, src_l, addr, wdata} = '0;
		cm_l = 16'h6000; // Message mode with drive on: the sequence must win
		cm_b = 16'h2000;
		repeat (8) @(posedge clk);
		check({rdata[4:0], waitreq, txb_l, oe_l, txb_b, oe_b}, 32'h0000_001A);
		rst_n <= 1'b1;
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].addr, rows[i].wdata);
			bus(1'b0, rows[i].addr, 32'h0000_0000);
			check(q, rows[i].rdata);
		end
		bus(1'b1, 4'h0, 32'h0000_0073);
		run <= 1'b1;
		repeat (100) @(posedge clk);
		bus(1'b0, 4'h0, 32'h0000_0000);
		check(q, 32'h0000_00FB);
		check({bad_l, bad_b}, 32'h0000_0000);
		flip_b <= 1'b1;
		repeat (37) @(posedge clk);
		flip_b <= 1'b0;
		bus(1'b0, 4'hD, 32'h0000_0000);
		check(q, {16'h0000, flips_b});
		check({16'h0000, flips_b}, 32'h0000_0025);
		flip_l <= 1'b1;
		repeat (65600) @(posedge clk);
		bus(1'b0, 4'h5, 32'h0000_0000);
		check(q, 32'h0000_FFFF);
		bus(1'b1, 4'h0, 32'h0000_0071);
		bus(1'b0, 4'h5, 32'h0000_0000);
		check(q, 32'h0000_FFFF);
		bus(1'b0, 4'h0, 32'h0000_0000);
		check(q, 32'h0000_00F1);
		bus(1'b1, 4'h0, 32'h0000_0073);
		bus(1'b0, 4'h5, 32'h0000_0000);
		check(q, 32'h0000_0000);
		cm_l <= 16'hA000; // Own side, connection mode, drive on
		src_l <= 1'b1;
		bus(1'b1, 4'h0, 32'h0000_0072);
		repeat (3) @(posedge clk);
		check({30'h0000_0000, txb_l, oe_l}, 32'h0000_0003);
		cm_l <= 16'h0000; // Other side, which is low, and output off
		repeat (3) @(posedge clk);
		check({30'h0000_0000, txb_l, oe_l}, 32'h0000_0000);
		stop_test;
	end
endmodule
